// ### common/rf_tx_regs.vh
/*
  register offsets, field positions and reset values of the rf transmitter
  configuration block. assumes a 32-bit apb slave, one register per word.
*/
`ifndef RF_TX_REGS_VH
`define RF_TX_REGS_VH

// register indices (printed offsets), byte address is four times these
`define IDX_TX_DRIVER_MODE 8'h28
`define IDX_TX_AMPLITUDE 8'h29
`define IDX_TX_MODULATION_CONTROL 8'h2a
`define IDX_TX_OVERSHOOT_LOAD 8'h2b

// writable bit masks; all other positions are reserved and read zero
`define MASK_TX_DRIVER_MODE 8'hcf
`define MASK_TX_AMPLITUDE 8'hdf
`define MASK_TX_MODULATION_CONTROL 8'hff
`define MASK_TX_OVERSHOOT_LOAD 8'hff

// reset values
`define RST_TX_DRIVER_MODE 8'h00
`define RST_TX_AMPLITUDE 8'h00
`define RST_TX_MODULATION_CONTROL 8'h00
`define RST_TX_OVERSHOOT_LOAD 8'h00

// driver mode fields
`define BIT_SECOND_DRIVER_INVERT 7
`define BIT_FIRST_DRIVER_INVERT 6
`define BIT_DRIVER_PINS_ENABLE 3
`define STYLE_MSB 2
`define STYLE_LSB 0
`define STYLE_BAD_A 3'h3
`define STYLE_BAD_B 3'h6

// amplitude fields
`define REDUCTION_MSB 7
`define REDUCTION_LSB 6
`define RESIDUAL_MSB 4
`define RESIDUAL_LSB 0

// modulation control fields
`define EXTRA_MSB 7
`define EXTRA_LSB 4
`define BIT_FULL_CARRIER 3
`define BIT_MODULATION_INVERT 2
`define SOURCE_MSB 1
`define SOURCE_LSB 0
`define SOURCE_NONE 2'h0
`define SOURCE_ENVELOPE 2'h1
`define SOURCE_EXTERNAL 2'h2

// overshoot and load fields
`define FIRST_MSB 7
`define FIRST_LSB 4
`define TRIM_MSB 3
`define TRIM_LSB 0

// carrier level reduction in millivolts for codes 0..3
`define REDUCTION_MV_0 11'h064
`define REDUCTION_MV_1 11'h0fa
`define REDUCTION_MV_2 11'h1f4
`define REDUCTION_MV_3 11'h3e8

`endif

// ### logic/rf_transmitter_config.v
/*
  rf transmitter configuration: apb register file for the two antenna
  drivers, modulation source selection and overshoot/load settings.
  assumes an apb master on pclk, the envelope signal from internal logic on
  pclk, and the external signal input and carrier clock arriving from pins.
*/
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "rf_tx_regs.vh"

module rf_transmitter_config (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire envelope_signal,
  input wire external_signal_input,
  input wire carrier_clock,
  output reg antenna_driver_one,
  output reg antenna_driver_two,
  output reg driver_pins_enable,
  output reg [2:0] driver_output_style,
  output reg style_unsupported,
  output reg [10:0] carrier_level_reduction,
  output reg full_carrier,
  output reg [4:0] residual_carrier,
  output reg [3:0] expected_load_trim,
  output reg overshoot_active
);

  reg [7:0] tx_driver_mode;
  reg [7:0] tx_amplitude;
  reg [7:0] tx_modulation_control;
  reg [7:0] tx_overshoot_load;

  // the four configuration bytes live here and nowhere else
  // every driver-side output below but overshoot_active is a registered copy or decode of these bytes, the antenna drivers together with the modulation,
  // so software sees a change on the pins one clock after its write lands
  // reserved positions are never stored, which keeps reads at zero
  // without a separate read mask
  // no reset value is documented for any of them; all start at zero,
  // which leaves both drivers off until software enables them

  // decode a byte address to a register select, one-hot over four
  function [3:0] reg_select;
    input [11:0] addr;
    begin
      reg_select = 4'h0;
      if (addr[1:0] == 2'h0) begin
        if (addr[11:2] == {2'h0, `IDX_TX_DRIVER_MODE}) reg_select = 4'h1;
        if (addr[11:2] == {2'h0, `IDX_TX_AMPLITUDE}) reg_select = 4'h2;
        if (addr[11:2] == {2'h0, `IDX_TX_MODULATION_CONTROL}) reg_select = 4'h4;
        if (addr[11:2] == {2'h0, `IDX_TX_OVERSHOOT_LOAD}) reg_select = 4'h8;
      end
    end
  endfunction

  wire setup_phase = psel & ~penable;
  wire [3:0] sel = reg_select(paddr);
  wire do_write = psel & penable & pready & pwrite & pstrb[0] & (sel != 4'h0);

  // apb handshake: one wait state, pready high in the second access cycle
  // cycle walk as seen by the master:
  //   setup: psel high, penable low
  //   first access cycle: psel and penable high, pready low
  //   second access cycle: pready high; write lands, read data stands
  //   next cycle: pready low again, ready for a new setup at once
  // the wait state lets read data come from a flop rather than from
  // the address decode, which keeps prdata a clean registered output
  // pslverr pulses with pready on an unmapped or misaligned word;
  // such a write is dropped and such a read returns zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & (sel == 4'h0);
      if (psel & penable & ~pready & ~pwrite) begin
        case (sel)
          4'h1: prdata <= {24'h000000, tx_driver_mode};
          4'h2: prdata <= {24'h000000, tx_amplitude};
          4'h4: prdata <= {24'h000000, tx_modulation_control};
          4'h8: prdata <= {24'h000000, tx_overshoot_load};
          default: prdata <= 32'h0000_0000;
        endcase
      end else if (setup_phase) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // register writes; masks keep reserved bits at zero
  // only byte lane 0 carries a register, so pstrb[0] alone gates writes;
  // a write with lane 0 off completes on the bus but changes nothing
  // the write commits at the edge where pready is sampled high, the same
  // edge at which the master takes the answer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_driver_mode <= `RST_TX_DRIVER_MODE;
      tx_amplitude <= `RST_TX_AMPLITUDE;
      tx_modulation_control <= `RST_TX_MODULATION_CONTROL;
      tx_overshoot_load <= `RST_TX_OVERSHOOT_LOAD;
    end else if (do_write) begin
      if (sel[0]) tx_driver_mode <= pwdata[7:0] & `MASK_TX_DRIVER_MODE;
      if (sel[1]) tx_amplitude <= pwdata[7:0] & `MASK_TX_AMPLITUDE;
      if (sel[2]) tx_modulation_control <= pwdata[7:0] & `MASK_TX_MODULATION_CONTROL;
      if (sel[3]) tx_overshoot_load <= pwdata[7:0] & `MASK_TX_OVERSHOOT_LOAD;
    end
  end

  // three-flop synchronisers for pin inputs; change accepted when stages 2 and 3 agree
  // the agreement test filters a single metastable resolution, at the
  // cost of three to four clocks of lag; the carrier must therefore run
  // well below pclk or rising edges will be merged and lost
  // bit 0 is the external modulation pin, bit 1 the carrier clock
  wire [1:0] pin_raw = {carrier_clock, external_signal_input};
  wire [1:0] pin_level;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : pin_sync
      reg [2:0] stage;
      reg level;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stage <= 3'h0;
          level <= 1'b0;
        end else begin
          stage <= {stage[1:0], pin_raw[g]};
          if (stage[1] == stage[2]) level <= stage[2];
        end
      end
      assign pin_level[g] = level;
    end
  endgenerate
  wire ext_level = pin_level[0];
  wire car_level = pin_level[1];

  // modulation source select and optional inversion
  // the envelope comes from logic on pclk and needs no synchroniser;
  // the external input is taken only after its synchroniser
  // the invert bit acts after the select, so with no source chosen
  // an inverted setting holds the modulation line high
  reg source_mod;
  always @* begin
    case (tx_modulation_control[`SOURCE_MSB:`SOURCE_LSB])
      `SOURCE_NONE: source_mod = 1'b0;
      `SOURCE_ENVELOPE: source_mod = envelope_signal;
      `SOURCE_EXTERNAL: source_mod = ext_level;
      default: source_mod = 1'b0; // reserved code behaves as none
    endcase
  end
  wire modulation = source_mod ^ tx_modulation_control[`BIT_MODULATION_INVERT];

  // overshoot prevention: on a modulation edge run first length, then extra
  // length, both counted in carrier clocks; each length latched as its own phase starts
  // a count of n lasts n + 1 carrier rises, since the phase ends on the
  // rise that finds the counter at zero
  // edges that arrive while a sequence runs are ignored: restarting
  // would stretch the protection without bound on a busy modulation line
  // overshoot_active marks the extra phase and trails it by one clock
  // changing either length field mid-sequence only affects the next phase
  // that loads it
  reg mod_prev;
  reg car_prev;
  reg [1:0] ov_state;
  reg [3:0] ov_count;
  localparam OV_IDLE = 2'h0;
  localparam OV_FIRST = 2'h1;
  localparam OV_EXTRA = 2'h2;
  wire car_rise = car_level & ~car_prev;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_prev <= 1'b0;
      car_prev <= 1'b0;
      ov_state <= OV_IDLE;
      ov_count <= 4'h0;
      overshoot_active <= 1'b0;
    end else begin
      mod_prev <= modulation;
      car_prev <= car_level;
      case (ov_state)
        OV_IDLE: begin
          if (modulation != mod_prev) begin
            ov_state <= OV_FIRST;
            ov_count <= tx_overshoot_load[`FIRST_MSB:`FIRST_LSB];
          end
        end
        OV_FIRST: begin
          if (car_rise) begin
            if (ov_count == 4'h0) begin
              ov_state <= OV_EXTRA;
              ov_count <= tx_modulation_control[`EXTRA_MSB:`EXTRA_LSB];
            end else begin
              ov_count <= ov_count - 4'h1;
            end
          end
        end
        OV_EXTRA: begin
          if (car_rise) begin
            if (ov_count == 4'h0) ov_state <= OV_IDLE;
            else ov_count <= ov_count - 4'h1;
          end
        end
        default: ov_state <= OV_IDLE;
      endcase
      overshoot_active <= (ov_state == OV_EXTRA);
    end
  end

  // reduction lookup in millivolts, overridden by full carrier
  // the value is handed to the analog stage as a plain millivolt figure;
  // eleven bits hold the largest preset with no scaling
  // used once today, kept as a function so a second consumer of the
  // preset table cannot drift from this one
  function [10:0] reduction_mv;
    input [1:0] code;
    begin
      case (code)
        2'h0: reduction_mv = `REDUCTION_MV_0;
        2'h1: reduction_mv = `REDUCTION_MV_1;
        2'h2: reduction_mv = `REDUCTION_MV_2;
        default: reduction_mv = `REDUCTION_MV_3;
      endcase
    end
  endfunction

  // registered driver outputs; unsupported styles fall back to high impedance
  // style code so a bad write cannot short the antenna drivers
  // the register itself keeps the code as written, so software reads back
  // what it wrote and can see the fault through style_unsupported
  // with the enable bit low both drivers are held low whatever the
  // invert bits say, so a disabled stage never idles at a high level
  // each driver takes its own invert bit on top of the shared modulation
  wire [2:0] style_field = tx_driver_mode[`STYLE_MSB:`STYLE_LSB];
  wire style_bad = (style_field == `STYLE_BAD_A) | (style_field == `STYLE_BAD_B);
  wire enable = tx_driver_mode[`BIT_DRIVER_PINS_ENABLE];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      antenna_driver_one <= 1'b0;
      antenna_driver_two <= 1'b0;
      driver_pins_enable <= 1'b0;
      driver_output_style <= 3'h0;
      style_unsupported <= 1'b0;
      carrier_level_reduction <= 11'h000;
      full_carrier <= 1'b0;
      residual_carrier <= 5'h00;
      expected_load_trim <= 4'h0;
    end else begin
      driver_pins_enable <= enable;
      antenna_driver_one <= enable & (modulation ^ tx_driver_mode[`BIT_FIRST_DRIVER_INVERT]);
      antenna_driver_two <= enable & (modulation ^ tx_driver_mode[`BIT_SECOND_DRIVER_INVERT]);
      driver_output_style <= style_bad ? 3'h0 : style_field;
      style_unsupported <= style_bad;
      full_carrier <= tx_modulation_control[`BIT_FULL_CARRIER];
      carrier_level_reduction <= tx_modulation_control[`BIT_FULL_CARRIER] ? 11'h000 :
        reduction_mv(tx_amplitude[`REDUCTION_MSB:`REDUCTION_LSB]);
      residual_carrier <= tx_amplitude[`RESIDUAL_MSB:`RESIDUAL_LSB];
      expected_load_trim <= tx_overshoot_load[`TRIM_MSB:`TRIM_LSB];
    end
  end

  // limitations worth knowing:
  // the trim is passed on as written; the analog stage applies it to the
  // modulation index, this block does no arithmetic on it
  // the residual carrier level likewise goes out unscaled
  // the reserved source code behaves as no modulation, so a stray write
  // of it leaves an unmodulated carrier rather than an undefined one
  // outputs change only on pclk; nothing here runs on the carrier itself

endmodule // rf_transmitter_config

// ### test/rf_transmitter_config_properties.sv
/* checker for rf_transmitter_config, bound to the ports of the block.
   assumes one apb wait state and byte addresses a0, a4, a8, ac. */
`timescale 1ns/1ps
module rf_transmitter_config_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire antenna_driver_one,
  input wire antenna_driver_two,
  input wire driver_pins_enable,
  input wire [2:0] driver_output_style,
  input wire style_unsupported,
  input wire [10:0] carrier_level_reduction,
  input wire full_carrier
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // bus answer: one wait state, single-cycle ready, error only on unmapped words
  chk_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready missing in second access cycle");
  chk_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready outside access or held");
  chk_addr_decode: assert property ((pready || pslverr) |-> pready
    && pslverr == !(paddr inside {12'ha0, 12'ha4, 12'ha8, 12'hac})) else $error("bad decode");
  chk_reserved_zero:
    assert property (pready && !pwrite |-> prdata[31:8] == 24'h0 && !(paddr == 12'ha0
    && prdata[5:4] != 2'h0) && !(paddr == 12'ha4 && prdata[5])) else $error("reserved read");
  // outputs against register state; the enable lands two edges after the write
  chk_enable_follows:
    assert property (psel && penable && pready && pwrite && pstrb[0] && paddr == 12'ha0
    |=> ##1 driver_pins_enable == $past(pwdata[3], 2)) else $error("enable not applied");
  chk_drivers_off:
    assert property (!driver_pins_enable |-> !antenna_driver_one && !antenna_driver_two)
    else $error("driver active while disabled");
  chk_style_forced:
    assert property (style_unsupported |-> driver_output_style == 3'h0)
    else $error("unsupported style passed on");
  chk_full_no_reduce:
    assert property (full_carrier |-> carrier_level_reduction == 11'h000)
    else $error("reduction with full carrier");
  chk_reduce_values:
    assert property (carrier_level_reduction != 11'h000 |-> carrier_level_reduction
    inside {11'h064, 11'h0fa, 11'h1f4, 11'h3e8}) else $error("reduction not a preset");
endmodule // rf_transmitter_config_checker

bind rf_transmitter_config rf_transmitter_config_checker u_rf_transmitter_config_checker (.*);

// ### test/rf_front_end_model.sv
/* front end model: free-running carrier and the external modulation pin.
   assumes pclk is fast enough for the block's synchronisers. */
`timescale 1ns/1ps
module rf_front_end_model (
  input wire pclk,
  input wire presetn,
  input wire ext_level,
  output reg carrier_clock,
  output reg external_signal_input
);
  reg [1:0] div;
  // carrier at an eighth of pclk so the three-flop sync never misses a level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 2'h0;
      carrier_clock <= 1'b0;
      external_signal_input <= 1'b0;
    end else begin
      div <= div + 2'h1;
      if (div == 2'h3) carrier_clock <= ~carrier_clock;
      external_signal_input <= ext_level;
    end
  end
endmodule // rf_front_end_model

// ### test/tb_rf_transmitter_config.sv
/* bench for rf_transmitter_config: apb tasks and output checks.
   assumes the front end model supplies carrier and external input. */
`timescale 1ns/1ps
module tb_rf_transmitter_config;
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  reg envelope_signal = 1'b0, ext_level = 1'b0;
  reg [3:0] pstrb = 4'hf;
  reg [11:0] paddr = 12'h000, a;
  reg [31:0] pwdata = 32'h0, rd;
  reg [10:0] mv;
  integer error_cnt = 0, n_compared = 0, rises = 0, j, c1, c2, t;
  wire [31:0] prdata;
  wire [10:0] carrier_level_reduction;
  wire [4:0] residual_carrier;
  wire [3:0] expected_load_trim;
  wire [2:0] driver_output_style;
  wire pready, pslverr, external_signal_input, carrier_clock, antenna_driver_one;
  wire antenna_driver_two, driver_pins_enable, style_unsupported, full_carrier, overshoot_active;
  always #10 pclk = ~pclk;
  always @(posedge carrier_clock) rises = rises + 1;
  rf_transmitter_config u_rf_transmitter_config (.*);
  rf_front_end_model u_rf_front_end_model (.pclk(pclk), .presetn(presetn), .ext_level(ext_level),
    .carrier_clock(carrier_clock), .external_signal_input(external_signal_input));
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input [31:0] exp, input [31:0] got, input [95:0] what);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("BAD %0s expected %h seen %h", what, exp, got);
    end
  endtask
  // one transfer; the request stands until pready is sampled high, bounded wait
  task apb(input wr, input [11:0] ad, input [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(negedge pclk);
      t = t + 1;
    end while (pready !== 1'b1 && t < 16);
    chk(32'h1, pready, "pready");
    if (pready !== 1'b1) give_verdict;
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // zero after reset, unmapped word refused, reserved bits masked
    for (a = 12'ha0; a < 12'hb0; a = a + 12'h4) begin
      apb(1'b0, a, 32'h0);
      chk(32'h0, rd, "reset_val");
      apb(1'b1, a, 32'hffff_ffff);
      apb(1'b0, a, 32'h0);
      chk({24'h0, a == 12'ha0 ? 8'hcf : a == 12'ha4 ? 8'hdf : 8'hff}, rd, "masked");
    end
    apb(1'b1, 12'hb0, 32'hff);
    chk(32'h1, err, "slverr");
    $display("test registers done");
    // drivers: every enable and invert combination with no modulation source
    apb(1'b1, 12'ha8, 32'h0);
    for (j = 0; j < 8; j = j + 1) begin
      apb(1'b1, 12'ha0, {24'h0, j[2:1], 2'b00, j[0], 3'b000});
      repeat (2) @(posedge pclk);
      chk(j[0], driver_pins_enable, "enable");
      chk(j[0] & j[1], antenna_driver_one, "drv_one");
      chk(j[0] & j[2], antenna_driver_two, "drv_two");
    end
    // output style codes, the two unsupported ones included on purpose
    for (j = 0; j < 8; j = j + 1) begin
      apb(1'b1, 12'ha0, j);
      repeat (2) @(posedge pclk);
      chk((j == 3 || j == 6) ? 0 : j, driver_output_style, "style");
      chk(j == 3 || j == 6, style_unsupported, "style_bad");
    end
    $display("test drivers done");
    // reduction presets with and without full carrier, residual level
    for (j = 0; j < 8; j = j + 1) begin
      mv = j[2] ? 11'h000 : j[1:0] == 0 ? 11'h064 : j[1:0] == 1 ? 11'h0fa
        : j[1:0] == 2 ? 11'h1f4 : 11'h3e8;
      apb(1'b1, 12'ha8, {28'h0, j[2], 3'b000});
      apb(1'b1, 12'ha4, {24'h0, j[1:0], 1'b1, j[4:0] ^ 5'h15});
      repeat (2) @(posedge pclk);
      chk(mv, carrier_level_reduction, "reduction");
      chk(j[2], full_carrier, "full");
      chk(j[4:0] ^ 5'h15, residual_carrier, "residual");
    end
    $display("test amplitude done");
    // sources with envelope high and external low; invert only on real sources
    apb(1'b1, 12'ha0, 32'h08);
    envelope_signal <= 1'b1;
    for (j = 0; j < 8; j = j + 1) begin
      apb(1'b1, 12'ha8, j);
      repeat (8) @(posedge pclk);
      if (j < 4 || j[1:0] == 1 || j[1:0] == 2)
        chk(j[1:0] == 1 ? !j[2] : j[2] & (j[1:0] == 2), antenna_driver_one, "mod");
    end
    $display("test modulation done");
    // overshoot phases counted in carrier rises, lag of the sync allowed
    apb(1'b1, 12'hac, 32'h15);
    repeat (2) @(posedge pclk);
    chk(32'h5, expected_load_trim, "trim");
    envelope_signal <= 1'b0;
    apb(1'b1, 12'ha8, 32'h21);
    repeat (80) @(posedge pclk);
    envelope_signal <= 1'b1;
    c1 = rises;
    for (t = 0; t < 400 && overshoot_active !== 1'b1; t = t + 1) @(posedge pclk);
    c1 = rises - c1;
    c2 = rises;
    for (t = 0; t < 400 && overshoot_active !== 1'b0; t = t + 1) @(posedge pclk);
    c2 = rises - c2;
    chk(1, c1 >= 1 && c1 <= 3, "first_len");
    chk(1, c2 >= 2 && c2 <= 4, "extra_len");
    $display("test overshoot done");
    give_verdict;
  end
endmodule // tb_rf_transmitter_config
